// ==== gpt_pkg.sv ====
`default_nettype none
package gpt_pkg;
	localparam int unsigned SRC_CLK_HZ      = 16000000;
	localparam int unsigned PRESCALE_FAST   = 4;
	localparam int unsigned PRESCALE_SLOW   = 512;
	localparam int unsigned PRESCALE_W      = 9;
	localparam int unsigned TIMER_W         = 16;
	localparam int unsigned PWM_W           = 8;
	localparam int unsigned ADDR_W          = 4;
	localparam int unsigned DATA_W          = 16;
	localparam logic [3:0] ADDR_CTRL        = 4'h0;
	localparam logic [3:0] ADDR_RELOAD      = 4'h1;
	localparam logic [3:0] ADDR_COUNT       = 4'h2;
	localparam logic [3:0] ADDR_PWM_HIGH    = 4'h3;
	localparam logic [3:0] ADDR_PWM_LOW     = 4'h4;
	localparam logic [3:0] ADDR_STATUS      = 4'h5;
	localparam logic [3:0] ADDR_MASK        = 4'h6;
	localparam int unsigned CTRL_RUN_BIT    = 0;
	localparam int unsigned CTRL_SLOW_BIT   = 1;
	localparam int unsigned CTRL_PWM_BIT    = 2;
	localparam int unsigned EVT_WRAP_BIT    = 0;
	localparam int unsigned EVT_PWM_BIT     = 1;
	localparam logic [2:0] CTRL_RESET       = 3'h0;
	localparam logic [15:0] RELOAD_RESET    = 16'hffff;
	localparam logic [7:0] PWM_HIGH_RESET   = 8'h01;
	localparam logic [7:0] PWM_LOW_RESET    = 8'h01;
	localparam logic [1:0] MASK_RESET       = 2'h0;
endpackage
`default_nettype wire

// ==== prescaler.sv ====
`default_nettype none
module prescaler
	import gpt_pkg::*;
(
	input  wire logic clock_in,
	input  wire logic sys_rst_in,
	input  wire logic clk_en_in,
	input  wire logic run_in,
	input  wire logic slow_in,
	output logic      tick_out
);
	logic [PRESCALE_W-1:0] cnt_r;
	wire  [PRESCALE_W-1:0] last_w = slow_in ? PRESCALE_W'(PRESCALE_SLOW - 1) : PRESCALE_W'(PRESCALE_FAST - 1);
	wire                   hit_w  = run_in && (cnt_r >= last_w);
	assign tick_out = hit_w;
	always_ff @(posedge clock_in) begin
		if (sys_rst_in)
			cnt_r <= '0;
		else if (clk_en_in)
			cnt_r <= (!run_in || hit_w) ? '0 : cnt_r + 1'b1;
	end
endmodule
`default_nettype wire

// ==== general_purpose_timer.sv ====
// The address-and-strobe port and the register addresses were chosen for this implementation.
`default_nettype none
// How it works
// R1: Sixteen-bit timer; software polls count or takes a maskable interrupt.
// R2: Auto-reload down counter fed by a prescaler of 4 or 512.
// R3: PWM mode drives the waveform onto the timer waveform pin.
// R4: High phase length and low phase length come from two 8-bit registers.
// R5: PWM phase counts advance at the same prescaled rate.
// R6: Source clock is the 16 MHz peripheral clock from the crystal divider.
// R7: Output high for high*ratio, low for low*ratio, repeating forever.
module general_purpose_timer
	import gpt_pkg::*;
(
	input  wire logic              clock_in,
	input  wire logic              sys_rst_in,
	input  wire logic              clk_en_in,
	input  wire logic [ADDR_W-1:0] addr_in,
	input  wire logic [DATA_W-1:0] wdata_in,
	input  wire logic              wr_in,
	input  wire logic              rd_in,
	output logic      [DATA_W-1:0] rdata_out,
	output logic                   irq_out,
	output logic                   timer_waveform_pin_out,
	output logic                   timer_waveform_pin_oe_out
);

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	logic [2:0]         ctrl_r;
	logic [TIMER_W-1:0] reload_r;
	logic [TIMER_W-1:0] count_r;
	logic [PWM_W-1:0]   pwm_high_r;
	logic [PWM_W-1:0]   pwm_low_r;
	logic [1:0]         status_r;
	logic [1:0]         mask_r;
	logic [PWM_W-1:0]   phase_r;
	logic               level_r;
	logic [DATA_W-1:0]  rdata_r;

	wire run_w  = ctrl_r[CTRL_RUN_BIT];
	wire slow_w = ctrl_r[CTRL_SLOW_BIT];
	wire pwm_w  = ctrl_r[CTRL_PWM_BIT];
	wire wr_ctrl_w   = wr_in && (addr_in == ADDR_CTRL);
	wire wr_reload_w = wr_in && (addr_in == ADDR_RELOAD);
	wire wr_high_w   = wr_in && (addr_in == ADDR_PWM_HIGH);
	wire wr_low_w    = wr_in && (addr_in == ADDR_PWM_LOW);
	wire wr_mask_w   = wr_in && (addr_in == ADDR_MASK);
	wire rd_stat_w   = rd_in && (addr_in == ADDR_STATUS);
	wire [PWM_W-1:0] wlow_w = wdata_in[PWM_W-1:0];

	// ------------------------------------------------------------
	// Prescaler
	// ------------------------------------------------------------
	wire tick_w;
	// R6: peripheral clock source
	// R2: selectable prescale ratio
	prescaler u_prescaler (
		.clock_in   (clock_in),
		.sys_rst_in (sys_rst_in),
		.clk_en_in  (clk_en_in),
		.run_in     (run_w),
		.slow_in    (slow_w),
		.tick_out   (tick_w)
	);

	// ------------------------------------------------------------
	// Counter and PWM
	// ------------------------------------------------------------
	// R2: reload on reaching zero
	wire wrap_w = tick_w && !pwm_w && (count_r == '0);
	wire [PWM_W-1:0] phase_len_w = level_r ? pwm_high_r : pwm_low_r;
	// R7: phase ends after its length in ticks
	wire phase_end_w = tick_w && pwm_w && (phase_r + 1'b1 >= phase_len_w);
	wire pwm_evt_w = phase_end_w && !level_r;
	wire [1:0] events_w = {pwm_evt_w, wrap_w};

	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			ctrl_r     <= CTRL_RESET;
			reload_r   <= RELOAD_RESET;
			pwm_high_r <= PWM_HIGH_RESET;
			pwm_low_r  <= PWM_LOW_RESET;
			mask_r     <= MASK_RESET;
		end else if (clk_en_in) begin
			if (wr_ctrl_w)
				ctrl_r <= wdata_in[2:0];
			if (wr_reload_w)
				reload_r <= wdata_in;
			// R4: phase length registers
			if (wr_high_w)
				pwm_high_r <= wdata_in[PWM_W-1:0];
			if (wr_low_w)
				pwm_low_r <= wdata_in[PWM_W-1:0];
			if (wr_mask_w)
				mask_r <= wdata_in[1:0];
		end
	end

	// R1: sixteen-bit down counter
	always_ff @(posedge clock_in) begin
		if (sys_rst_in)
			count_r <= RELOAD_RESET;
		else if (clk_en_in) begin
			if (wr_reload_w || !run_w)
				count_r <= wr_reload_w ? wdata_in : reload_r;
			else if (wrap_w)
				count_r <= reload_r;
			else if (tick_w && !pwm_w)
				count_r <= count_r - 1'b1;
		end
	end

	// R5: phase count steps on prescaled tick
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			phase_r <= '0;
			level_r <= 1'b1;
		end else if (clk_en_in) begin
			if (!run_w || !pwm_w) begin
				phase_r <= '0;
				level_r <= 1'b1;
			end else if (phase_end_w) begin
				phase_r <= '0;
				level_r <= !level_r;
			end else if (tick_w)
				phase_r <= phase_r + 1'b1;
		end
	end

	// R3: waveform onto the pin in PWM mode
	assign timer_waveform_pin_out    = level_r && run_w && pwm_w;
	assign timer_waveform_pin_oe_out = pwm_w;

	// ------------------------------------------------------------
	// Status, interrupt and readback
	// ------------------------------------------------------------
	// R1: sticky flags, set wins over read clear
	always_ff @(posedge clock_in) begin
		if (sys_rst_in)
			status_r <= '0;
		else if (clk_en_in)
			status_r <= (rd_stat_w ? 2'h0 : status_r) | events_w;
	end
	assign irq_out = |(status_r & mask_r);

	logic [DATA_W-1:0] rmux_w;
	always_comb begin
		case (addr_in)
			ADDR_CTRL:     rmux_w = {13'h0, ctrl_r};
			ADDR_RELOAD:   rmux_w = reload_r;
			ADDR_COUNT:    rmux_w = count_r;
			ADDR_PWM_HIGH: rmux_w = {8'h0, pwm_high_r};
			ADDR_PWM_LOW:  rmux_w = {8'h0, pwm_low_r};
			ADDR_STATUS:   rmux_w = {14'h0, status_r};
			ADDR_MASK:     rmux_w = {14'h0, mask_r};
			default:       rmux_w = 16'h0000;
		endcase
	end
	always_ff @(posedge clock_in) begin
		if (sys_rst_in)
			rdata_r <= '0;
		else if (clk_en_in)
			rdata_r <= rd_in ? rmux_w : 16'h0000;
	end
	assign rdata_out = rdata_r;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	// R2: reload after zero
	property p_reload;
		@(posedge clock_in) disable iff (sys_rst_in)
		(clk_en_in && wrap_w && !wr_reload_w && run_w) |=> (count_r == $past(reload_r));
	endproperty
	a_reload: assert property (p_reload) else $error("no reload after wrap"); // R2
	// R1: wrap sets flag
	property p_wrap_flag;
		@(posedge clock_in) disable iff (sys_rst_in)
		(clk_en_in && wrap_w) |=> status_r[EVT_WRAP_BIT];
	endproperty
	a_wrap_flag: assert property (p_wrap_flag) else $error("wrap flag lost"); // R1
	// R1: interrupt follows mask
	property p_irq;
		@(posedge clock_in) disable iff (sys_rst_in)
		(clk_en_in && ((events_w & mask_r) != 2'h0) && !wr_mask_w) |=> irq_out;
	endproperty
	a_irq: assert property (p_irq) else $error("irq mismatch"); // R1
	// R2: fast ratio tick spacing
	property p_fast;
		@(posedge clock_in) disable iff (sys_rst_in)
		(tick_w && clk_en_in && !slow_w && !wr_ctrl_w) ##1 (clk_en_in && run_w && !slow_w && !wr_ctrl_w)[*3]
			|=> tick_w;
	endproperty
	a_fast: assert property (p_fast) else $error("fast ratio not 4"); // R2
	// R5: no phase advance without tick
	property p_phase;
		@(posedge clock_in) disable iff (sys_rst_in)
		(clk_en_in && run_w && pwm_w && !tick_w && !wr_ctrl_w) |=> $stable(phase_r) && $stable(level_r);
	endproperty
	a_phase: assert property (p_phase) else $error("phase moved without tick"); // R5
	// R7: level toggles at phase end
	property p_toggle;
		@(posedge clock_in) disable iff (sys_rst_in)
		(clk_en_in && phase_end_w && run_w && !wr_ctrl_w) |=> (level_r != $past(level_r)) && (phase_r == 8'h00);
	endproperty
	a_toggle: assert property (p_toggle) else $error("no toggle at phase end"); // R7
	// R3: pin idle low outside PWM
	property p_pin;
		@(posedge clock_in) disable iff (sys_rst_in)
		(clk_en_in && wr_ctrl_w && !wdata_in[CTRL_PWM_BIT]) |=> !timer_waveform_pin_out && !timer_waveform_pin_oe_out;
	endproperty
	a_pin: assert property (p_pin) else $error("pin driven outside pwm"); // R3
	// R4: written high length kept
	property p_high_wr;
		@(posedge clock_in) disable iff (sys_rst_in)
		(clk_en_in && wr_high_w) |=> (pwm_high_r == $past(wlow_w));
	endproperty
	a_high_wr: assert property (p_high_wr) else $error("high length not stored"); // R4
	// R4: written low length kept
	property p_low_wr;
		@(posedge clock_in) disable iff (sys_rst_in)
		(clk_en_in && wr_low_w) |=> (pwm_low_r == $past(wlow_w));
	endproperty
	a_low_wr: assert property (p_low_wr) else $error("low length not stored"); // R4
	// R7: waveform starts high
	property p_start_high;
		@(posedge clock_in) disable iff (sys_rst_in)
		(clk_en_in && wr_ctrl_w && wdata_in[CTRL_RUN_BIT] && wdata_in[CTRL_PWM_BIT] && !pwm_w)
			|=> timer_waveform_pin_out && timer_waveform_pin_oe_out;
	endproperty
	a_start_high: assert property (p_start_high) else $error("pwm did not start high"); // R7
	// R7: period end flagged
	property p_pwm_evt;
		@(posedge clock_in) disable iff (sys_rst_in)
		(clk_en_in && pwm_evt_w) |=> status_r[EVT_PWM_BIT];
	endproperty
	a_pwm_evt: assert property (p_pwm_evt) else $error("pwm period flag lost"); // R7

	// ------------------------------------------------------------
	// Checks on counter, bus and status
	// ------------------------------------------------------------
	// R2: count steps down
	property p_count_step;
		@(posedge clock_in) disable iff (sys_rst_in)
		(clk_en_in && run_w && !pwm_w && tick_w && (count_r != 16'h0000) && !wr_reload_w)
			|=> (count_r == $past(count_r) - 16'h0001);
	endproperty
	a_count_step: assert property (p_count_step) else $error("count did not step down"); // R2
	// R2: count holds between ticks
	property p_count_hold;
		@(posedge clock_in) disable iff (sys_rst_in)
		(clk_en_in && run_w && !tick_w && !wr_reload_w) |=> $stable(count_r);
	endproperty
	a_count_hold: assert property (p_count_hold) else $error("count moved without tick"); // R2
	// R2: no counting in PWM
	property p_count_pwm;
		@(posedge clock_in) disable iff (sys_rst_in)
		(clk_en_in && run_w && pwm_w && !wr_reload_w) |=> $stable(count_r);
	endproperty
	a_count_pwm: assert property (p_count_pwm) else $error("count moved in pwm mode"); // R2
	// R2: idle count follows reload
	property p_idle_follow;
		@(posedge clock_in) disable iff (sys_rst_in)
		(clk_en_in && !run_w && !wr_reload_w) |=> (count_r == $past(reload_r));
	endproperty
	a_idle_follow: assert property (p_idle_follow) else $error("idle count not reload"); // R2
	// R2: reload write loads count
	property p_reload_wr;
		@(posedge clock_in) disable iff (sys_rst_in)
		(clk_en_in && wr_reload_w) |=> (reload_r == $past(wdata_in)) && (count_r == $past(wdata_in));
	endproperty
	a_reload_wr: assert property (p_reload_wr) else $error("reload write not stored"); // R2
	// R1: count readback
	property p_rd_count;
		@(posedge clock_in) disable iff (sys_rst_in)
		(clk_en_in && rd_in && (addr_in == ADDR_COUNT)) |=> (rdata_out == $past(count_r));
	endproperty
	a_rd_count: assert property (p_rd_count) else $error("count readback wrong"); // R1
	// R1: status readback
	property p_rd_status;
		@(posedge clock_in) disable iff (sys_rst_in)
		(clk_en_in && rd_stat_w) |=> (rdata_out == {14'h0, $past(status_r)});
	endproperty
	a_rd_status: assert property (p_rd_status) else $error("status readback wrong"); // R1
	// R1: read data zero otherwise
	property p_rd_zero;
		@(posedge clock_in) disable iff (sys_rst_in)
		(clk_en_in && !rd_in) |=> (rdata_out == 16'h0000);
	endproperty
	a_rd_zero: assert property (p_rd_zero) else $error("read data not zero"); // R1
	// R1: status read clears
	property p_stat_clear;
		@(posedge clock_in) disable iff (sys_rst_in)
		(clk_en_in && rd_stat_w && (events_w == 2'h0)) |=> (status_r == 2'h0);
	endproperty
	a_stat_clear: assert property (p_stat_clear) else $error("status not cleared"); // R1
	// R1: status bits sticky
	property p_stat_hold;
		@(posedge clock_in) disable iff (sys_rst_in)
		(clk_en_in && !rd_stat_w) |=> ((status_r & $past(status_r)) == $past(status_r));
	endproperty
	a_stat_hold: assert property (p_stat_hold) else $error("status bit lost"); // R1
	// R1: clock enable freezes state
	property p_freeze;
		@(posedge clock_in) disable iff (sys_rst_in)
		!clk_en_in |=> $stable(count_r) && $stable(status_r) && $stable(phase_r) && $stable(level_r)
			&& $stable(ctrl_r) && $stable(rdata_out);
	endproperty
	a_freeze: assert property (p_freeze) else $error("state moved while frozen"); // R1
endmodule
`default_nettype wire

// ==== pin_load.sv ====
`default_nettype none
// ----------------------------------------
// Load on the waveform pin
// ----------------------------------------
module pin_load (
	input  wire logic        clock_in,
	input  wire logic        pin_in,
	input  wire logic        oe_in,
	output logic      [15:0] high_len_out,
	output logic      [15:0] low_len_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] run_r;
	logic        last_r;
	always_ff @(posedge clock_in) begin
		if (oe_in !== 1'b1) begin
			run_r <= 16'h0001;
			last_r <= pin_in;
		end else if (pin_in == last_r) begin
			run_r <= run_r + 16'h0001;
		end else begin
			if (last_r) high_len_out <= run_r;
			else low_len_out <= run_r;
			run_r <= 16'h0001;
			last_r <= pin_in;
		end
	end
endmodule
`default_nettype wire

// ==== general_purpose_timer_tb.sv ====
`default_nettype none
module general_purpose_timer_tb;
	import gpt_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock_in, sys_rst_in, clk_en_in, wr_in, rd_in, irq_out, pin_out, oe_out;
	logic [ADDR_W-1:0] addr_in;
	logic [DATA_W-1:0] wdata_in, rdata_out;
	logic [15:0]       high_len, low_len;
	int                n_errors, n_tests;
	general_purpose_timer u_general_purpose_timer (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
		.clk_en_in(clk_en_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
		.rdata_out(rdata_out), .irq_out(irq_out), .timer_waveform_pin_out(pin_out),
		.timer_waveform_pin_oe_out(oe_out));
	pin_load u_pin_load (.clock_in(clock_in), .pin_in(pin_out), .oe_in(oe_out),
		.high_len_out(high_len), .low_len_out(low_len));
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		n_tests++;
		if (got !== exp) begin
			$display("wrong value %s expected %h seen %h", name, exp, got);
			n_errors++;
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clock_in);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge clock_in);
		wr_in <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [15:0] exp, input string name);
		@(posedge clock_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge clock_in);
		rd_in <= 1'b0;
		@(negedge clock_in);
		chk(name, exp, rdata_out);
	endtask
	task automatic wait_irq(input int lo, input int hi);
		int n;
		n = 0;
		while (irq_out !== 1'b1 && n < hi) begin
			@(negedge clock_in);
			n++;
		end
		chk("irq delay in range", 16'h0001, {15'h0, n >= lo && n < hi});
		if (n >= hi) test_done();
	endtask
	task automatic test_done();
		$display("tests %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		rd(ADDR_CTRL, {13'h0, CTRL_RESET}, "ctrl");
		rd(ADDR_RELOAD, RELOAD_RESET, "reload");
		rd(ADDR_PWM_HIGH, {8'h0, PWM_HIGH_RESET}, "pwm high");
		rd(ADDR_PWM_LOW, {8'h0, PWM_LOW_RESET}, "pwm low");
		rd(ADDR_MASK, {14'h0, MASK_RESET}, "mask");
		rd(4'hf, 16'h0000, "unmapped");
		chk("pin enable", 16'h0000, {15'h0, oe_out});
		chk("pin level", 16'h0000, {15'h0, pin_out});
		chk("irq after reset", 16'h0000, {15'h0, irq_out});
		$display("reset test done");
	endtask
	task automatic t_fast();
		wr(ADDR_RELOAD, 16'h0003);
		rd(ADDR_COUNT, 16'h0003, "count follows reload");
		wr(ADDR_MASK, 16'h0001);
		wr(ADDR_CTRL, 16'h0001);
		wait_irq(4 * PRESCALE_FAST + 1, 4 * PRESCALE_FAST + 2);
		wr(ADDR_CTRL, 16'h0000);
		rd(ADDR_STATUS, 16'h0001, "wrap status");
		rd(ADDR_STATUS, 16'h0000, "status after read");
		chk("irq cleared", 16'h0000, {15'h0, irq_out});
		$display("fast timer test done");
	endtask
	task automatic t_slow();
		wr(ADDR_RELOAD, 16'h0001);
		wr(ADDR_CTRL, 16'h0003);
		wait_irq(2 * PRESCALE_SLOW + 1, 2 * PRESCALE_SLOW + 2);
		wr(ADDR_CTRL, 16'h0000);
		rd(ADDR_STATUS, 16'h0001, "slow wrap status");
		$display("slow timer test done");
	endtask
	task automatic t_pwm();
		wr(ADDR_PWM_HIGH, 16'h0003);
		wr(ADDR_PWM_LOW, 16'h0005);
		wr(ADDR_CTRL, 16'h0005);
		repeat (120) @(posedge clock_in);
		chk("pin enable", 16'h0001, {15'h0, oe_out});
		chk("high length", 16'(3 * PRESCALE_FAST), high_len);
		chk("low length", 16'(5 * PRESCALE_FAST), low_len);
		chk("masked irq", 16'h0000, {15'h0, irq_out});
		rd(ADDR_STATUS, 16'h0002, "pwm status");
		wr(ADDR_MASK, 16'h0002);
		wait_irq(1, 34);
		wr(ADDR_CTRL, 16'h0000);
		$display("pwm test done");
	endtask
	task automatic t_pwm_slow();
		wr(ADDR_PWM_HIGH, 16'h0001);
		wr(ADDR_PWM_LOW, 16'h0002);
		wr(ADDR_CTRL, 16'h0007);
		repeat (1700) @(posedge clock_in);
		chk("slow high length", 16'(PRESCALE_SLOW), high_len);
		chk("slow low length", 16'(2 * PRESCALE_SLOW), low_len);
		wr(ADDR_CTRL, 16'h0000);
		$display("slow pwm test done");
	endtask
	task automatic t_freeze();
		wr(ADDR_RELOAD, 16'h0100);
		wr(ADDR_CTRL, 16'h0001);
		repeat (10) @(posedge clock_in);
		clk_en_in <= 1'b0;
		repeat (50) @(posedge clock_in);
		clk_en_in <= 1'b1;
		rd(ADDR_COUNT, 16'h00fe, "count frozen");
		wr(ADDR_CTRL, 16'h0000);
		$display("clock enable test done");
	endtask
	task automatic t_midreset();
		wr(ADDR_PWM_HIGH, 16'h00aa);
		wr(ADDR_CTRL, 16'h0005);
		repeat (20) @(posedge clock_in);
		sys_rst_in <= 1'b1;
		repeat (2) @(posedge clock_in);
		sys_rst_in <= 1'b0;
		t_reset();
		$display("mid-run reset test done");
	endtask
	initial begin
		clock_in = 1'b0;
		forever #50 clock_in = ~clock_in;
	end
	initial begin
		n_errors = 0;
		n_tests = 0;
		sys_rst_in = 1'b1;
		clk_en_in = 1'b1;
		wr_in = 1'b0;
		rd_in = 1'b0;
		addr_in = '0;
		wdata_in = '0;
		repeat (12) @(posedge clock_in);
		sys_rst_in <= 1'b0;
		t_reset();
		t_fast();
		t_slow();
		t_freeze();
		t_pwm();
		t_pwm_slow();
		t_midreset();
		test_done();
	end
endmodule
`default_nettype wire
